// ===== hdl/mbox_ram_pkg.sv
// package for the mailbox message store: register map, field positions, carriers
// assumes an apb master with 32-bit data and a protocol engine on the same clock
//
// Function
// - there are 16 mailboxes, and each has eight byte-wide control bytes numbered one to eight.
// - control storage is ram that powers up undefined, and software writes every bit before use.
// - byte one bits 3..0 hold the frame length code; 0..8 mean that many bytes and 9..15 mean eight bytes.
// - byte five bit 4 chooses a data frame (0) or a remote frame (1).
// - byte five bit 3 chooses the standard (0) or extended (1) identifier format.
// - the identifier sits in byte six (28..21), byte five 7..5 (20..18), 1..0 (17..16), byte eight (15..8), byte seven (7..0).
// - byte five bit 2 and byte one bits 7..4 are spare storage that software initialises.
// - bytes two, three and four are plain read/write storage with no function.
// - each mailbox also has eight byte-wide payload bytes in ram, undefined until written.
// - reset clears every control register except the mailbox control and payload ram.
// - for mailbox 0 each set acceptance mask bit removes that identifier bit from the comparison.
package mbox_ram_pkg;

  // =========================================================================
  // geometry
  localparam int MBOX_NUM       = 16;
  localparam int MBOX_BYTES     = 8;
  localparam int RAM_WORDS      = MBOX_NUM * MBOX_BYTES;
  localparam int ADDR_W         = 12;

  // =========================================================================
  // word indices on the bus (byte address = 4 * index)
  localparam logic [9:0] CTRL_BASE_IDX   = 10'h000;
  localparam logic [9:0] DATA_BASE_IDX   = 10'h080;
  localparam logic [9:0] MASK_LO_IDX     = 10'h100;
  localparam logic [9:0] MASK_HI_IDX     = 10'h101;
  localparam logic [9:0] STATUS_IDX      = 10'h102;

  // =========================================================================
  // byte positions inside a mailbox (byte index minus one)
  localparam logic [2:0] LEN_BYTE        = 3'h0;
  localparam logic [2:0] FLAGS_BYTE      = 3'h4;
  localparam logic [2:0] ID_HIGH_BYTE    = 3'h5;
  localparam logic [2:0] ID_LOW_BYTE     = 3'h6;
  localparam logic [2:0] ID_MID_BYTE     = 3'h7;

  // =========================================================================
  // field positions
  localparam int REMOTE_BIT     = 4;
  localparam int EXT_BIT        = 3;
  localparam logic [3:0] MAX_LEN        = 4'h8;
  localparam logic [15:0] MASK_HI_WMASK = 16'he3ff;
  localparam logic [28:0] STD_ID_BITS   = 29'h1ffc_0000;
  localparam logic [15:0] MASK_RESET    = 16'h0000;

  // =========================================================================
  // carriers
  typedef struct packed {
    logic [3:0]  len_bytes;
    logic        remote;
    logic        ext;
    logic [28:0] id;
    logic [63:0] payload;
  } eng_view_t;

  typedef struct packed {
    logic        valid;
    logic [3:0]  mbox;
    logic [3:0]  len_code;
    logic [63:0] payload;
  } eng_store_t;

  typedef struct packed {
    logic        valid;
    logic        ext;
    logic [28:0] id;
  } rx_check_t;

endpackage

// ===== hdl/mbox_ram.sv
// mailbox message store: 16 mailboxes of control and payload bytes, apb slave,
// a read view and a store port for the protocol engine, mailbox 0 acceptance check
// assumes one clock, synchronous active-high reset, engine ports synchronous to ref_clk
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/10ps
module mbox_ram
  import mbox_ram_pkg::*;
(
  input  wire logic                           ref_clk,
  input  wire logic                           rst,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [mbox_ram_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                    pwdata,
  input  wire logic [3:0]                     pstrb,
  output logic [31:0]                         prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire logic [3:0]                     eng_view_mbox,
  output mbox_ram_pkg::eng_view_t             eng_view,
  input  mbox_ram_pkg::eng_store_t            eng_store,
  input  mbox_ram_pkg::rx_check_t             rx_check,
  output logic                                rx_match,
  output logic                                rx_match_valid
);
  import mbox_ram_pkg::*;

  // =========================================================================
  // state
  typedef struct packed {
    logic [RAM_WORDS-1:0][7:0] ctrl;
    logic [RAM_WORDS-1:0][7:0] data;
    logic [15:0]               mask_lo;
    logic [15:0]               mask_hi;
    logic [31:0]               prdata;
    eng_view_t                 view;
    logic                      match;
    logic                      match_valid;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // =========================================================================
  // helpers
  function automatic logic [3:0] dlc_bytes(input logic [3:0] code);
    return (code > MAX_LEN) ? MAX_LEN : code;
  endfunction

  function automatic logic [28:0] id_of(input logic [7:0] b5, input logic [7:0] b6,
                                        input logic [7:0] b7, input logic [7:0] b8);
    return {b6, b5[7:5], b5[1:0], b8, b7};
  endfunction

  function automatic logic [6:0] slot(input logic [3:0] mbox, input logic [2:0] pos);
    return {mbox, pos};
  endfunction

  // =========================================================================
  // bus decode
  logic [9:0] word_idx;
  logic       sel_ctrl;
  logic       sel_data;
  logic       sel_mlo;
  logic       sel_mhi;
  logic       sel_stat;
  logic       mapped;
  logic       do_wr;
  logic       do_rd_setup;
  logic [3:0] acc_mbox;
  logic [2:0] acc_pos;

  assign word_idx    = paddr[ADDR_W-1:2];
  assign sel_ctrl    = (word_idx >= CTRL_BASE_IDX) && (word_idx < DATA_BASE_IDX);
  assign sel_data    = (word_idx >= DATA_BASE_IDX) && (word_idx < MASK_LO_IDX);
  assign sel_mlo     = (word_idx == MASK_LO_IDX);
  assign sel_mhi     = (word_idx == MASK_HI_IDX);
  assign sel_stat    = (word_idx == STATUS_IDX);
  assign mapped      = sel_ctrl | sel_data | sel_mlo | sel_mhi | sel_stat;
  assign acc_mbox    = word_idx[6:3];
  assign acc_pos     = word_idx[2:0];
  assign pready      = psel & penable;
  assign pslverr     = psel & penable & ~mapped;
  assign do_wr       = psel & penable & pwrite & mapped;
  assign do_rd_setup = psel & ~penable & ~pwrite;

  // =========================================================================
  // mailbox 0 identifier compare
  logic [28:0] mb0_id;
  logic [28:0] care;
  logic [28:0] fmt_bits;
  logic        mb0_ext;
  logic        hit;

  assign mb0_id   = id_of(st_r.ctrl[slot(4'h0, FLAGS_BYTE)], st_r.ctrl[slot(4'h0, ID_HIGH_BYTE)],
                          st_r.ctrl[slot(4'h0, ID_LOW_BYTE)], st_r.ctrl[slot(4'h0, ID_MID_BYTE)]);
  assign mb0_ext  = st_r.ctrl[slot(4'h0, FLAGS_BYTE)][EXT_BIT];
  // mask fields share the mailbox byte layout, so one function serves both
  assign care     = ~id_of(st_r.mask_hi[15:8], st_r.mask_hi[7:0],
                           st_r.mask_lo[15:8], st_r.mask_lo[7:0]);
  assign fmt_bits = rx_check.ext ? {29{1'b1}} : STD_ID_BITS;
  assign hit      = (rx_check.ext == mb0_ext) &&
                    (((rx_check.id ^ mb0_id) & care & fmt_bits) == 29'h0000_0000);

  // =========================================================================
  // next state
  always_comb begin
    logic [6:0] base;
    base   = slot(eng_view_mbox, LEN_BYTE);
    st_nxt = st_r;
    // engine view of the chosen mailbox, registered so the data leaves a flop
    st_nxt.view.len_bytes = dlc_bytes(st_r.ctrl[base][3:0]);
    st_nxt.view.remote    = st_r.ctrl[slot(eng_view_mbox, FLAGS_BYTE)][REMOTE_BIT];
    st_nxt.view.ext       = st_r.ctrl[slot(eng_view_mbox, FLAGS_BYTE)][EXT_BIT];
    st_nxt.view.id        = id_of(st_r.ctrl[slot(eng_view_mbox, FLAGS_BYTE)],
                                  st_r.ctrl[slot(eng_view_mbox, ID_HIGH_BYTE)],
                                  st_r.ctrl[slot(eng_view_mbox, ID_LOW_BYTE)],
                                  st_r.ctrl[slot(eng_view_mbox, ID_MID_BYTE)]);
    for (int k = 0; k < MBOX_BYTES; k++) begin
      st_nxt.view.payload[8*k +: 8] = st_r.data[slot(eng_view_mbox, 3'(k))];
    end
    st_nxt.match_valid = rx_check.valid;
    if (rx_check.valid) begin
      st_nxt.match = hit;
    end
    // engine store: length nibble and payload; spare upper nibble is left alone
    if (eng_store.valid) begin
      st_nxt.ctrl[slot(eng_store.mbox, LEN_BYTE)][3:0] = eng_store.len_code;
      for (int k = 0; k < MBOX_BYTES; k++) begin
        st_nxt.data[slot(eng_store.mbox, 3'(k))] = eng_store.payload[8*k +: 8];
      end
    end
    // cpu write lands after the engine so software wins a same-cycle clash
    if (do_wr) begin
      if (sel_ctrl && pstrb[0]) begin
        st_nxt.ctrl[slot(acc_mbox, acc_pos)] = pwdata[7:0];
      end
      if (sel_data && pstrb[0]) begin
        st_nxt.data[slot(acc_mbox, acc_pos)] = pwdata[7:0];
      end
      if (sel_mlo) begin
        for (int b = 0; b < 2; b++) begin
          if (pstrb[b]) begin
            st_nxt.mask_lo[8*b +: 8] = pwdata[8*b +: 8];
          end
        end
      end
      if (sel_mhi) begin
        for (int b = 0; b < 2; b++) begin
          if (pstrb[b]) begin
            st_nxt.mask_hi[8*b +: 8] = pwdata[8*b +: 8] & MASK_HI_WMASK[8*b +: 8];
          end
        end
      end
    end
    // read data captured in setup so it comes from a flop in the access phase
    if (do_rd_setup) begin
      st_nxt.prdata = 32'h0000_0000;
      if (sel_ctrl) begin
        st_nxt.prdata[7:0] = st_r.ctrl[slot(acc_mbox, acc_pos)];
      end else if (sel_data) begin
        st_nxt.prdata[7:0] = st_r.data[slot(acc_mbox, acc_pos)];
      end else if (sel_mlo) begin
        st_nxt.prdata[15:0] = st_r.mask_lo;
      end else if (sel_mhi) begin
        st_nxt.prdata[15:0] = st_r.mask_hi;
      end else if (sel_stat) begin
        st_nxt.prdata[1:0] = {st_r.match_valid, st_r.match};
      end
    end
    // reset spares the ram: it has no reset and software must fill it
    if (rst) begin
      st_nxt.mask_lo     = MASK_RESET;
      st_nxt.mask_hi     = MASK_RESET;
      st_nxt.prdata      = 32'h0000_0000;
      st_nxt.view        = '0;
      st_nxt.match       = 1'b0;
      st_nxt.match_valid = 1'b0;
      st_nxt.ctrl        = st_r.ctrl;
      st_nxt.data        = st_r.data;
    end
  end

  always_ff @(posedge ref_clk) begin
    st_r <= st_nxt;
  end

  assign prdata         = st_r.prdata;
  assign eng_view       = st_r.view;
  assign rx_match       = st_r.match;
  assign rx_match_valid = st_r.match_valid;

  // =========================================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic wr_ctrl_only;
  assign wr_ctrl_only = do_wr && sel_ctrl && pstrb[0];

  a_ctrl_write_store: assert property (
    wr_ctrl_only |=> st_r.ctrl[$past(slot(acc_mbox, acc_pos))] === $past(pwdata[7:0]))
    else $error("control byte write not stored");

  // ram is unknown until software fills it, so views are compared with case equality
  a_view_len_clip: assert property (
    1'b1 |=> eng_view.len_bytes === dlc_bytes($past(st_r.ctrl[slot(eng_view_mbox, LEN_BYTE)][3:0])))
    else $error("length code decode wrong");

  a_view_remote_bit: assert property (
    1'b1 |=> eng_view.remote === $past(st_r.ctrl[slot(eng_view_mbox, FLAGS_BYTE)][REMOTE_BIT]))
    else $error("remote flag wrong");

  a_view_ext_bit: assert property (
    1'b1 |=> eng_view.ext === $past(st_r.ctrl[slot(eng_view_mbox, FLAGS_BYTE)][EXT_BIT]))
    else $error("extended flag wrong");

  a_view_id_high: assert property (
    1'b1 |=> eng_view.id[28:21] === $past(st_r.ctrl[slot(eng_view_mbox, ID_HIGH_BYTE)]) &&
             eng_view.id[7:0] === $past(st_r.ctrl[slot(eng_view_mbox, ID_LOW_BYTE)]))
    else $error("identifier mapping wrong");

  a_spare_nibble_kept: assert property (
    (eng_store.valid && !do_wr) |=>
      st_r.ctrl[$past(slot(eng_store.mbox, LEN_BYTE))][7:4] ==
      $past(st_r.ctrl[slot(eng_store.mbox, LEN_BYTE)][7:4]))
    else $error("spare nibble changed by engine store");

  // must not be disabled by reset, it watches the reset itself
  a_ram_survives_reset: assert property (@(posedge ref_clk) disable iff (1'b0)
    rst |=> st_r.ctrl === $past(st_r.ctrl) && st_r.data === $past(st_r.data) &&
            st_r.mask_lo == MASK_RESET && st_r.mask_hi == MASK_RESET)
    else $error("reset touched ram or missed masks");

  a_mask_full_hit: assert property (
    (rx_check.valid && rx_check.ext == mb0_ext && care == 29'h0000_0000) |=> rx_match && rx_match_valid)
    else $error("fully masked id did not match");

  a_unmapped_error: assert property (
    (psel && penable && word_idx > STATUS_IDX) |-> pslverr && pready)
    else $error("unmapped access not flagged");

  a_payload_read_back: assert property (
    (do_rd_setup && sel_data) |=> prdata === {24'h00_0000, $past(st_r.data[slot(acc_mbox, acc_pos)])})
    else $error("payload byte read back wrong");

  c_ctrl_write: cover property (wr_ctrl_only);
  c_payload_read: cover property (do_rd_setup && sel_data ##1 pready);
  c_rx_match: cover property (rx_check.valid ##1 rx_match);
  c_unmapped: cover property (pslverr);

endmodule

// ===== tb/engine_model.sv
// protocol engine model: view select, message store and mailbox 0 check requests
// assumes its tasks are called from the bench, each waiting for a rising edge first
`timescale 1ns/10ps
module engine_model
  import mbox_ram_pkg::*;
(
  input  wire logic                 ref_clk,
  output logic [3:0]                eng_view_mbox,
  output mbox_ram_pkg::eng_store_t  eng_store,
  output mbox_ram_pkg::rx_check_t   rx_check
);
  import mbox_ram_pkg::*;

  initial begin
    eng_view_mbox = 4'h0;
    eng_store     = '0;
    rx_check      = '0;
  end

  // =========================================================================
  // requests
  task automatic sel(input logic [3:0] m);
    @(posedge ref_clk);
    eng_view_mbox <= m;
  endtask

  // released fields show inverted data so nothing is read by luck
  task automatic store(input logic [3:0] m, input logic [3:0] len, input logic [63:0] pl);
    @(posedge ref_clk);
    eng_store <= '{1'b1, m, len, pl};
    @(posedge ref_clk);
    eng_store <= '{1'b0, ~m, ~len, ~pl};
  endtask

  task automatic check(input logic ext, input logic [28:0] id);
    @(posedge ref_clk);
    rx_check <= '{1'b1, ext, id};
    @(posedge ref_clk);
    rx_check <= '{1'b0, ~ext, ~id};
  endtask
endmodule

// ===== tb/mbox_ram_test.sv
// self-checking bench for the mailbox message store: apb master, engine model
// assumes zero-wait apb slave and byte address = 4 * byte number (payload from 0x200)
`timescale 1ns/10ps
module mbox_ram_test;
  import mbox_ram_pkg::*;
  logic                ref_clk = 1'b0;
  logic                rst = 1'b1;
  logic                psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [ADDR_W-1:0]   paddr = '0;
  logic [31:0]         pwdata = '0, prdata, rd, r, r2, seed = 32'h0000_aeb9;
  logic                rx_match, rx_match_valid, cext;
  logic [3:0]          eng_view_mbox;
  logic [15:0]         mlo = 16'h0000, mhi = 16'h0000;
  logic [28:0]         cid;
  logic [7:0]          mem [0:255];
  eng_view_t           eng_view, ev;
  eng_store_t          eng_store;
  rx_check_t           rx_check;
  int                  error_cnt = 0, n_compared = 0;

  always #5 ref_clk = ~ref_clk;

  mbox_ram uut(.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .eng_view_mbox(eng_view_mbox), .eng_view(eng_view), .eng_store(eng_store), .rx_check(rx_check),
    .rx_match(rx_match), .rx_match_valid(rx_match_valid));
  engine_model eng(.ref_clk(ref_clk), .eng_view_mbox(eng_view_mbox), .eng_store(eng_store),
    .rx_check(rx_check));

  // =========================================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic eng_view_t exp_view(input int m);
    eng_view_t v;
    v.len_bytes = (mem[m*8][3:0] > 4'h8) ? 4'h8 : mem[m*8][3:0];
    v.remote    = mem[m*8+4][4];
    v.ext       = mem[m*8+4][3];
    v.id        = {mem[m*8+5], mem[m*8+4][7:5], mem[m*8+4][1:0], mem[m*8+7], mem[m*8+6]};
    for (int k = 0; k < 8; k++) v.payload[8*k+:8] = mem[128+m*8+k];
    return v;
  endfunction

  // standard format leaves id 17..0 out of the comparison
  function automatic logic exp_match(input logic ext, input logic [28:0] id);
    logic [28:0] dc;
    dc = {mhi[7:0], mhi[15:13], mhi[9:8], mlo[7:0], mlo[15:8]} | (ext ? 29'h0000_0000 : 29'h0003_ffff);
    return (ext == mem[4][3]) && (((id ^ exp_view(0).id) & ~dc) == 29'h0000_0000);
  endfunction

  task automatic stop_test();
    $display("comparisons %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one transfer; an idle edge first so no signal is driven twice in a step
  task automatic apb(input logic wr, input int a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a[ADDR_W-1:0];
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // =========================================================================
  // main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk("prdata", prdata, 32'h0000_0000);
    chk("match valid", rx_match_valid, 1'b0);
    for (int i = 0; i < 256; i++) begin
      r = rnd();
      mem[i] = r[7:0];
      apb(1'b1, i * 4, r);
    end
    for (int i = 0; i < 256; i++) begin
      apb(1'b0, i * 4, 32'h0000_0000);
      chk("ram byte", rd, {24'h00_0000, mem[i]});
    end
    for (int m = 0; m < 16; m++) begin
      eng.sel(m[3:0]);
      repeat (2) @(posedge ref_clk);
      chk("engine view", eng_view, exp_view(m));
    end
    eng.sel(4'h3);
    for (int c = 0; c < 16; c++) begin
      mem[24] = {mem[24][7:4], c[3:0]};
      apb(1'b1, 24 * 4, {24'h00_0000, mem[24]});
      repeat (2) @(posedge ref_clk);
      chk("length", eng_view.len_bytes, exp_view(3).len_bytes);
    end
    r = rnd();
    r2 = rnd();
    eng.store(4'h5, r[3:0], {r, r2});
    mem[40][3:0] = r[3:0];
    for (int k = 0; k < 8; k++) mem[168+k] = 8'({r, r2} >> (8 * k));
    eng.sel(4'h5);
    repeat (2) @(posedge ref_clk);
    chk("stored view", eng_view, exp_view(5));
    apb(1'b0, 40 * 4, 32'h0000_0000);
    chk("stored length byte", rd, {24'h00_0000, mem[40]});
    for (int j = 0; j < 48; j++) begin
      if (j == 24 || j == 40) begin
        // second pass masks every identifier bit, so only the format flag decides
        r = (j == 40) ? 32'hffff_ffff : rnd();
        mlo = r[15:0];
        mhi = r[31:16] & 16'he3ff;
        apb(1'b1, 12'h400, {16'h0000, mlo});
        apb(1'b1, 12'h404, {16'h0000, r[31:16]});
        apb(1'b0, 12'h404, 32'h0000_0000);
        chk("mask high", rd, {16'h0000, mhi});
      end
      r = rnd();
      r2 = rnd();
      ev = exp_view(0);
      cext = (j % 8 == 7) ? ~ev.ext : (j % 5 == 4) ? 1'b0 : ev.ext;
      cid = ev.id ^ (r[28:0] & r2[28:0] & {29{j[0]}});
      eng.check(cext, cid);
      #1;
      chk("match valid", rx_match_valid, 1'b1);
      chk("match", rx_match, exp_match(cext, cid));
    end
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    apb(1'b0, 12'h400, 32'h0000_0000);
    chk("mask after reset", rd, 32'h0000_0000);
    apb(1'b0, 170 * 4, 32'h0000_0000);
    chk("payload kept", rd, {24'h00_0000, mem[170]});
    apb(1'b1, 12'h40c, 32'h0000_00ff);
    chk("unmapped write error", err, 1'b1);
    apb(1'b0, 12'h40c, 32'h0000_0000);
    chk("unmapped read", {err, rd}, {1'b1, 32'h0000_0000});
    stop_test();
  end
endmodule
